//--- rtl/arwc_pkg.sv
/*
 * shared constants, types and wait-code table of the area read wait control.
 * assumes a 32-bit apb register port and a single bus clock.
 */
package arwc_pkg;

	// bus geometry
	localparam int ARWC_AW = 8;
	localparam int ARWC_DW = 32;

	// register byte offsets
	localparam logic [7:0] ARWC_OFS_CFG_A = 8'h00;
	localparam logic [7:0] ARWC_OFS_CFG_B = 8'h04;
	localparam logic [7:0] ARWC_OFS_STATUS = 8'h08;

	// configuration field positions
	localparam int ARWC_WR_LSB = 7;
	localparam int ARWC_WR_MSB = 10;
	localparam int ARWC_WM_BIT = 6;

	// status field positions
	localparam int ARWC_ST_BUSY_BIT = 0;
	localparam int ARWC_ST_AREA_BIT = 1;
	localparam int ARWC_ST_STRETCH_BIT = 2;
	localparam int ARWC_ST_BADCODE_BIT = 3;
	localparam int ARWC_ST_CNT_LSB = 8;

	// reset values
	localparam logic [3:0] ARWC_WR_RST = 4'h a;
	localparam logic ARWC_WM_RST = 1'b0;

	// wait counter width
	localparam int ARWC_CNT_W = 5;

	// wait cycles per code, prohibited codes run as the longest
	localparam logic [4:0] ARWC_WAIT_LUT [16] = '{
		5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h08,
		5'h0a, 5'h0c, 5'h0e, 5'h12, 5'h18, 5'h18, 5'h18, 5'h18
	};
	localparam logic [3:0] ARWC_WR_MAX_CODE = 4'h c;

	typedef struct packed {
		logic [3:0] wait_code;
		logic ext_wait_mask;
	} arwc_cfg_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [ARWC_AW-1:0] paddr;
		logic [ARWC_DW-1:0] pwdata;
		logic [3:0] pstrb;
	} arwc_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [ARWC_DW-1:0] prdata;
		logic pslverr;
	} arwc_apb_rsp_t;

	typedef enum logic [3:0] {
		ARWC_ST_IDLE = 4'b0001,
		ARWC_ST_WAIT = 4'b0010,
		ARWC_ST_EXTW = 4'b0100,
		ARWC_ST_END = 4'b1000
	} arwc_state_t;

endpackage

//--- rtl/arwc_wait_cnt.sv
/*
 * wait-cycle down counter, loaded from a decoded wait code.
 * assumes load and decrement never come in the same cycle.
 */
`timescale 1ns/100ps
module arwc_wait_cnt #(
	parameter int CNT_W = arwc_pkg::ARWC_CNT_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// control
	input wire logic load,
	input wire logic [3:0] code,
	input wire logic dec,
	// state
	output logic [CNT_W-1:0] cnt_q,
	output logic zero
);
	import arwc_pkg::*;

	logic [CNT_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (load) begin
			cnt_d = CNT_W'(ARWC_WAIT_LUT[code]);
		end else if (dec && cnt_q != '0) begin
			cnt_d = cnt_q - CNT_W'(1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign zero = (cnt_q == '0);

endmodule // arwc_wait_cnt

//--- rtl/arwc_top.sv
/*
 * area read wait control: two area configuration registers on apb,
 * and a read strobe sequencer that inserts programmed and external waits.
 * assumes rd_req and ext_wait_n synchronous to pclk; requester holds
 * rd_req until rd_done.
 */
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/100ps
// What this block does
// - read wait field bits 10..7 selects 0-6, 8, 10, 12, 14, 18, 24 wait cycles
// - wait field resets to code 1010, fourteen waits per read
// - mask bit 6 clear honours external wait, set ignores it; resets clear
// - mask setting applies even with zero programmed waits
// - bits 5..2 read zero; software writes zeros there
module arwc_top #(
	parameter int CNT_W = arwc_pkg::ARWC_CNT_W
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire arwc_pkg::arwc_apb_req_t apb_req,
	output arwc_pkg::arwc_apb_rsp_t apb_rsp,
	// read access request
	input wire logic rd_req,
	input wire logic rd_area,
	output logic rd_busy_q,
	output logic rd_done_q,
	// external memory side
	output logic rd_strobe_n_q,
	input wire logic ext_wait_n
);
	import arwc_pkg::*;

	arwc_cfg_t cfg_q [2];
	arwc_apb_rsp_t rsp_q;
	arwc_state_t state_q;
	logic area_q;
	logic mask_q;
	logic stretch_q;
	logic badcode_q;
	logic setup;
	logic access;
	logic wr_en;
	logic [ARWC_DW-1:0] rd_data;
	logic rd_hit;
	logic [CNT_W-1:0] cnt;
	logic cnt_zero;
	logic cnt_load;
	logic cnt_dec;
	logic ext_hold;
	logic [1:0] cfg_wr;
	logic bad_wr;
	logic stretch_set;
	logic stretch_clr;
	logic badcode_clr;
	logic [3:0] code_nx [2];
	logic mask_nx [2];
	logic [ARWC_DW-1:0] cfg_word [2];
	logic [ARWC_DW-1:0] status_word;
	logic [1:0] bad_area;
	logic acc_end;
	logic in_acc;

	// apb phase decode
	assign setup = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign wr_en = access && apb_req.pwrite && rsp_q.pready;

	// per-area register write strobes
	assign cfg_wr[0] = wr_en && apb_req.paddr == ARWC_OFS_CFG_A;
	assign cfg_wr[1] = wr_en && apb_req.paddr == ARWC_OFS_CFG_B;

	// area configuration registers
	for (genvar g = 0; g < 2; g++) begin : g_area
		// next wait code, each byte lane only when strobed
		always_comb begin
			code_nx[g] = cfg_q[g].wait_code;
			if (apb_req.pstrb[0]) begin
				code_nx[g][0] = apb_req.pwdata[ARWC_WR_LSB];
			end
			if (apb_req.pstrb[1]) begin
				code_nx[g][3:1] = apb_req.pwdata[ARWC_WR_MSB:ARWC_WR_LSB+1];
			end
		end

		// next mask, low byte lane only
		always_comb begin
			mask_nx[g] = cfg_q[g].ext_wait_mask;
			if (apb_req.pstrb[0]) begin
				mask_nx[g] = apb_req.pwdata[ARWC_WM_BIT];
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cfg_q[g].wait_code <= ARWC_WR_RST;
				cfg_q[g].ext_wait_mask <= ARWC_WM_RST;
			end else if (cfg_wr[g]) begin
				cfg_q[g].wait_code <= code_nx[g];
				cfg_q[g].ext_wait_mask <= mask_nx[g];
			end
		end

		// prohibited code as it would land, lanes merged
		assign bad_area[g] = cfg_wr[g] && code_nx[g] > ARWC_WR_MAX_CODE;

		// read-back image, reserved bits zero
		always_comb begin
			cfg_word[g] = '0;
			cfg_word[g][ARWC_WR_MSB:ARWC_WR_LSB] = cfg_q[g].wait_code;
			cfg_word[g][ARWC_WM_BIT] = cfg_q[g].ext_wait_mask;
		end
	end

	// prohibited code written by software, either area
	assign bad_wr = |bad_area;

	// status clear strobes, write one to clear
	always_comb begin
		stretch_clr = 1'b0;
		badcode_clr = 1'b0;
		if (wr_en && apb_req.paddr == ARWC_OFS_STATUS && apb_req.pstrb[0]) begin
			stretch_clr = apb_req.pwdata[ARWC_ST_STRETCH_BIT];
			badcode_clr = apb_req.pwdata[ARWC_ST_BADCODE_BIT];
		end
	end

	// sticky prohibited-code flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			badcode_q <= 1'b0;
		end else if (bad_wr) begin
			badcode_q <= 1'b1;
		end else if (badcode_clr) begin
			badcode_q <= 1'b0;
		end
	end

	// sticky stretched-access flag, set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stretch_q <= 1'b0;
		end else if (stretch_set) begin
			stretch_q <= 1'b1;
		end else if (stretch_clr) begin
			stretch_q <= 1'b0;
		end
	end

	// status image
	always_comb begin
		status_word = '0;
		status_word[ARWC_ST_BUSY_BIT] = rd_busy_q;
		status_word[ARWC_ST_AREA_BIT] = area_q;
		status_word[ARWC_ST_STRETCH_BIT] = stretch_q;
		status_word[ARWC_ST_BADCODE_BIT] = badcode_q;
		status_word[ARWC_ST_CNT_LSB +: CNT_W] = cnt;
	end

	// read data mux, unused bits zero
	always_comb begin
		rd_data = '0;
		rd_hit = 1'b1;
		case (apb_req.paddr)
			ARWC_OFS_CFG_A: begin
				rd_data = cfg_word[0];
			end
			ARWC_OFS_CFG_B: begin
				rd_data = cfg_word[1];
			end
			ARWC_OFS_STATUS: begin
				rd_data = status_word;
			end
			default: begin
				rd_hit = 1'b0;
			end
		endcase
	end

	// apb answer, one access cycle, error on unmapped address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_q <= '0;
		end else begin
			rsp_q.pready <= setup;
			rsp_q.pslverr <= setup && !rd_hit;
			if (setup && !apb_req.pwrite) begin
				rsp_q.prdata <= rd_data;
			end else begin
				rsp_q.prdata <= '0;
			end
		end
	end

	assign apb_rsp = rsp_q;

	// wait counter
	assign cnt_load = state_q == ARWC_ST_IDLE && rd_req;
	assign cnt_dec = state_q == ARWC_ST_WAIT;

	arwc_wait_cnt #(
		.CNT_W(CNT_W)
	) u_cnt (
		.pclk(pclk),
		.presetn(presetn),
		.load(cnt_load),
		.code(cfg_q[rd_area].wait_code),
		.dec(cnt_dec),
		.cnt_q(cnt),
		.zero(cnt_zero)
	);

	// external wait honoured only while unmasked
	assign ext_hold = !mask_q && !ext_wait_n;
	assign in_acc = state_q == ARWC_ST_WAIT || state_q == ARWC_ST_EXTW;
	assign stretch_set = ((state_q == ARWC_ST_WAIT && cnt_zero) ||
		state_q == ARWC_ST_EXTW) && ext_hold;

	// access ends once counted waits are out and no wait is held
	assign acc_end = ((state_q == ARWC_ST_WAIT && cnt_zero) ||
		state_q == ARWC_ST_EXTW) && !ext_hold;

	// access context latched at start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			area_q <= 1'b0;
			mask_q <= ARWC_WM_RST;
		end else if (cnt_load) begin
			area_q <= rd_area;
			mask_q <= cfg_q[rd_area].ext_wait_mask;
		end
	end

	// read access sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ARWC_ST_IDLE;
		end else begin
			case (state_q)
				ARWC_ST_IDLE: begin
					if (rd_req) begin
						state_q <= ARWC_ST_WAIT;
					end
				end
				ARWC_ST_WAIT: begin
					if (cnt_zero) begin
						if (ext_hold) begin
							state_q <= ARWC_ST_EXTW;
						end else begin
							state_q <= ARWC_ST_END;
						end
					end
				end
				ARWC_ST_EXTW: begin
					if (!ext_hold) begin
						state_q <= ARWC_ST_END;
					end
				end
				ARWC_ST_END: begin
					state_q <= ARWC_ST_IDLE;
				end
				default: begin
					state_q <= ARWC_ST_IDLE;
				end
			endcase
		end
	end

	// read strobe, low from accept to the end of the access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_strobe_n_q <= 1'b1;
		end else if (cnt_load) begin
			rd_strobe_n_q <= 1'b0;
		end else if (acc_end || !in_acc) begin
			rd_strobe_n_q <= 1'b1;
		end
	end

	// busy from accept through the closing cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_busy_q <= 1'b0;
		end else if (cnt_load) begin
			rd_busy_q <= 1'b1;
		end else if (!in_acc) begin
			rd_busy_q <= 1'b0;
		end
	end

	// done pulse, one cycle as the strobe returns high
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_done_q <= 1'b0;
		end else begin
			rd_done_q <= acc_end;
		end
	end

endmodule // arwc_top

//--- test/arwc_assertions.sv
/* port checker of arwc_top.
   assumes bind to arwc_top, one pclk domain. */
`timescale 1ns/100ps
module arwc_assertions (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire arwc_pkg::arwc_apb_req_t apb_req,
	input wire arwc_pkg::arwc_apb_rsp_t apb_rsp,
	// read access
	input wire logic rd_req,
	input wire logic rd_area,
	input wire logic rd_busy_q,
	input wire logic rd_done_q,
	input wire logic rd_strobe_n_q,
	input wire logic ext_wait_n
);
	import arwc_pkg::*;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_rdy;
		apb_req.psel && !apb_req.penable |=> apb_rsp.pready ##1 !apb_rsp.pready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("pready timing");
	property p_zero;
		apb_rsp.pready && !apb_req.pwrite && apb_req.paddr < ARWC_OFS_STATUS
			|-> apb_rsp.prdata[31:11] == 0 && apb_rsp.prdata[5:0] == 0;
	endproperty
	a_zero: assert property (p_zero) else $error("cfg spare bits");
	property p_err;
		apb_rsp.pready && apb_req.paddr > ARWC_OFS_STATUS |-> apb_rsp.pslverr;
	endproperty
	a_err: assert property (p_err) else $error("no slverr");
	property p_quiet;
		!apb_rsp.pready |-> apb_rsp.prdata == 0 && !apb_rsp.pslverr;
	endproperty
	a_quiet: assert property (p_quiet) else $error("rsp not quiet");
	property p_start;
		!rd_busy_q && rd_req |=> !rd_strobe_n_q && rd_busy_q && !rd_done_q;
	endproperty
	a_start: assert property (p_start) else $error("no strobe");
	property p_done;
		$rose(rd_strobe_n_q) |-> rd_done_q && rd_busy_q;
	endproperty
	a_done: assert property (p_done) else $error("done late");
	property p_once;
		rd_done_q |=> !rd_done_q && !rd_busy_q;
	endproperty
	a_once: assert property (p_once) else $error("done stuck");
	property p_idle;
		!rd_busy_q |-> rd_strobe_n_q && !rd_done_q;
	endproperty
	a_idle: assert property (p_idle) else $error("strobe idle");
endmodule // arwc_assertions
bind arwc_top arwc_assertions arwc_assertions_inst (.pclk(pclk), .presetn(presetn),
	.apb_req(apb_req), .apb_rsp(apb_rsp), .rd_req(rd_req), .rd_area(rd_area),
	.rd_busy_q(rd_busy_q), .rd_done_q(rd_done_q), .rd_strobe_n_q(rd_strobe_n_q),
	.ext_wait_n(ext_wait_n));

//--- test/arwc_mem_model.sv
/* memory wait model: wait during a strobe window.
   assumes window set by the bench. */
`timescale 1ns/100ps
module arwc_mem_model (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// window, in strobe cycles
	input wire logic [7:0] dly,
	input wire logic [7:0] hold,
	// pins
	input wire logic rd_strobe_n_q,
	output logic ext_wait_n
);
	int k_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			k_q <= 0;
		else
			k_q <= rd_strobe_n_q ? 0 : k_q + 1;
	end
	// wait only inside window
	assign ext_wait_n = !(!rd_strobe_n_q && k_q >= dly && k_q < dly + hold);
endmodule // arwc_mem_model

//--- test/arwc_top_tb.sv
/* testbench of arwc_top.
   assumes arwc_mem_model as far side. */
`timescale 1ns/100ps
module arwc_top_tb;
	import arwc_pkg::*;
	logic pclk = 0;
	logic presetn = 0;
	arwc_apb_req_t req = '0;
	arwc_apb_rsp_t rsp;
	logic rd_req = 0;
	logic rd_area = 0;
	logic busy, done, stb_n, wt_n, e;
	logic [7:0] dly = 0;
	logic [7:0] hold = 0;
	logic [31:0] r;
	int err_total = 0;
	int cmp_count = 0;
	int n;
	int wt [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
	int bc [3] = '{0, 2, 2};
	int bd [3] = '{0, 2, 0};
	int bh [3] = '{2, 4, 2};
	int bx [3] = '{3, 7, 3};
	always #5 pclk = ~pclk;
	arwc_top arwc_top_inst (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
		.rd_req(rd_req), .rd_area(rd_area), .rd_busy_q(busy), .rd_done_q(done),
		.rd_strobe_n_q(stb_n), .ext_wait_n(wt_n));
	arwc_mem_model arwc_mem_model_inst (.pclk(pclk), .presetn(presetn), .dly(dly),
		.hold(hold), .rd_strobe_n_q(stb_n), .ext_wait_n(wt_n));
	task end_of_test;
		if (err_total == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		cmp_count++;
		if (g !== x) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, g, x);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d, 4'hf};
		@(posedge pclk);
		req.penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (rsp.pready !== 1'b1 && i < 50);
		chk(rsp.pready, 1'b1);
		if (rsp.pready !== 1'b1)
			end_of_test;
		r = rsp.prdata;
		e = rsp.pslverr;
		req <= '0;
	endtask
	task rd(input logic ar);
		int i;
		@(posedge pclk);
		rd_req <= 1'b1;
		rd_area <= ar;
		n = 0;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
			if (stb_n === 1'b0)
				n++;
		end while (done !== 1'b1 && i < 100);
		chk(done, 1'b1);
		if (done !== 1'b1)
			end_of_test;
		rd_req <= 1'b0;
		@(posedge pclk);
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ARWC_OFS_CFG_A, '0);
		chk(r, 32'h0000_0500);
		apb(1'b0, ARWC_OFS_CFG_B, '0);
		chk(r, 32'h0000_0500);
		rd(1'b0);
		chk(n, 32'h0000_000f);
		hold <= 8'h03;
		// codes 0000 to 1100 only, mask set
		for (int c = 0; c < 13; c++) begin
			apb(1'b1, ARWC_OFS_CFG_A, 32'(c << 7) | 32'h0000_0040);
			apb(1'b0, ARWC_OFS_CFG_A, '0);
			chk(r, 32'(c << 7) | 32'h0000_0040);
			rd(1'b0);
			chk(n, wt[c] + 1);
		end
		for (int j = 0; j < 3; j++) begin
			dly <= 8'(bd[j]);
			hold <= 8'(bh[j]);
			apb(1'b1, ARWC_OFS_CFG_B, 32'hffff_f800 | 32'(bc[j]) << 7);
			apb(1'b0, ARWC_OFS_CFG_B, '0);
			chk(r, 32'(bc[j]) << 7);
			rd(1'b1);
			chk(n, bx[j]);
		end
		apb(1'b0, ARWC_OFS_STATUS, '0);
		chk(r, 32'h0000_0006);
		apb(1'b1, ARWC_OFS_STATUS, 32'h0000_0004);
		apb(1'b0, ARWC_OFS_STATUS, '0);
		chk(r, 32'h0000_0002);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, ARWC_OFS_CFG_B, '0);
		chk(r, 32'h0000_0500);
		apb(1'b0, ARWC_OFS_STATUS, '0);
		chk(r, 32'h0000_0000);
		apb(1'b1, 8'h0c, 32'hffff_ffff);
		apb(1'b0, 8'h0c, '0);
		chk({r[30:0], e}, 32'h0000_0001);
		end_of_test;
	end
endmodule // arwc_top_tb
